// ---- lcc_order.sv ----
// Purpose: Orders two operands of a selected type (less, equal, not-a-number)
// Assumes: Purely combinational; caller registers the outcome
// Notes:   Signed and float values map to unsigned keys so one compare serves all
`default_nettype none

module lcc_order
    import lcc_pkg::*;
(
    input wire lcc_pkg::lcc_type_t dtype, // Operand type
    input wire logic [31:0] x_val, // Left-hand operand
    input wire logic [31:0] y_val, // Right-hand operand
    output logic less, // x below y
    output logic equal, // x equals y
    output logic nan // Either float operand is not-a-number
);

    // ------------------------------------------------------------------
    // Width normalisation of short types
    // ------------------------------------------------------------------
    logic [31:0] x_norm;
    logic [31:0] y_norm;
    logic is_short;
    logic is_signed_int;
    logic is_float;
    assign is_short = (dtype == LCC_SIGNED_INT_TYPE) || (dtype == LCC_WORD_TYPE);
    assign is_signed_int = (dtype == LCC_SIGNED_INT_TYPE) || (dtype == signed_double_type);
    assign is_float = (dtype == LCC_FLOAT_TYPE);
    assign x_norm = !is_short ? x_val : (dtype == LCC_WORD_TYPE) ? {16'h0000, x_val[15:0]}
                  : {{LCC_SHORT_W{x_val[15]}}, x_val[15:0]};
    assign y_norm = !is_short ? y_val : (dtype == LCC_WORD_TYPE) ? {16'h0000, y_val[15:0]}
                  : {{LCC_SHORT_W{y_val[15]}}, y_val[15:0]};

    // ------------------------------------------------------------------
    // Order-preserving keys: two's complement and sign-magnitude
    // ------------------------------------------------------------------
    logic [31:0] x_key;
    logic [31:0] y_key;
    logic both_zero;
    logic x_nan;
    logic y_nan;
    assign x_key = is_float ? (x_norm[31] ? ~x_norm : (x_norm ^ LCC_SIGN_MASK))
                 : is_signed_int ? (x_norm ^ LCC_SIGN_MASK) : x_norm;
    assign y_key = is_float ? (y_norm[31] ? ~y_norm : (y_norm ^ LCC_SIGN_MASK))
                 : is_signed_int ? (y_norm ^ LCC_SIGN_MASK) : y_norm;
    assign both_zero = is_float && ((x_norm & LCC_MAG_MASK) == 32'h0)
                     && ((y_norm & LCC_MAG_MASK) == 32'h0);
    assign x_nan = ((x_norm & LCC_EXP_MASK) == LCC_EXP_MASK) && ((x_norm & LCC_FRAC_MASK) != 32'h0);
    assign y_nan = ((y_norm & LCC_EXP_MASK) == LCC_EXP_MASK) && ((y_norm & LCC_FRAC_MASK) != 32'h0);

    // Outcome; a not-a-number operand is unordered
    assign nan = is_float && (x_nan || y_nan);
    assign less = !nan && !both_zero && (x_key < y_key);
    assign equal = !nan && (both_zero || (x_key == y_key));

endmodule : lcc_order

`default_nettype wire

// ---- lcc_pkg.sv ----
// Purpose: Shared types and constants for the ladder compare and contact unit
// Assumes: Operands travel in 32-bit containers; 16-bit types use the low half
// Notes:   Operator and type codes are internal encodings of the sweep engine
`default_nettype none

package lcc_pkg;

    // ------------------------------------------------------------------
    // Widths and masks
    // ------------------------------------------------------------------
    localparam int LCC_DATA_W = 32;
    localparam int LCC_SHORT_W = 16;
    localparam logic [31:0] LCC_SIGN_MASK = 32'h8000_0000;
    localparam logic [31:0] LCC_MAG_MASK = 32'h7fff_ffff;
    localparam logic [31:0] LCC_EXP_MASK = 32'h7f80_0000;
    localparam logic [31:0] LCC_FRAC_MASK = 32'h007f_ffff;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic LCC_FLOW_RST = 1'b0;
    localparam logic LCC_FLAG_RST = 1'b0;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LCC_EQUAL_OP,
        LCC_NOT_EQUAL_OP,
        LCC_GREATER_OP,
        LCC_GREATER_OR_EQUAL_OP,
        LCC_LESS_OP,
        less_or_equal_op
    } lcc_op_t;

    typedef enum logic [1:0] {
        LCC_SIGNED_INT_TYPE,
        signed_double_type,
        LCC_WORD_TYPE,
        LCC_FLOAT_TYPE
    } lcc_type_t;

    typedef enum logic [1:0] {
        LCC_OPEN_CONTACT,
        LCC_CLOSED_CONTACT,
        LCC_CONT_CONTACT,
        LCC_NO_CONTACT
    } lcc_contact_t;

    // ------------------------------------------------------------------
    // Request carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic enable;
        lcc_op_t op;
        lcc_type_t dtype;
        logic [31:0] first_operand;
        logic [31:0] second_operand;
    } lcc_cmp_req_t;

    typedef struct packed {
        logic enable;
        lcc_type_t dtype;
        logic [31:0] test_value;
        logic [31:0] range_limit_a;
        logic [31:0] range_limit_b;
    } lcc_range_req_t;

    typedef struct packed {
        lcc_contact_t kind;
        logic flow_in;
        logic ref_bit;
        logic coil_exec;
        logic coil_flow;
        logic sweep_start;
    } lcc_relay_req_t;

endpackage : lcc_pkg

`default_nettype wire

// ---- lcc_unit.sv ----
// Purpose: Relational compare, range test and contact flow for one rung step
// Assumes: Sweep engine presents operands and flow synchronous to clock
// Notes:   Flows are sampled at the edge that takes the enable and held one cycle; the float flag holds until the next float compare
`default_nettype none

module lcc_unit
    import lcc_pkg::*;
(
    input wire logic clock, // 250 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire lcc_pkg::lcc_cmp_req_t cmp_req, // Relational compare request
    input wire lcc_pkg::lcc_range_req_t range_req, // Range test request
    input wire lcc_pkg::lcc_relay_req_t relay_req, // Contact and continuation coil step
    output logic cmp_flow, // Compare result flow
    output logic range_flow, // Range result flow
    output logic float_compare_ok_flag, // Float compare status flag
    output logic contact_flow // Contact output flow
);

    import lcc_pkg::*;

    // ------------------------------------------------------------------
    // Operand ordering
    // ------------------------------------------------------------------
    logic cmp_less;
    logic cmp_equal;
    logic cmp_nan;
    logic a_less;
    logic a_equal;
    logic b_less;
    logic b_equal;

    // First operand on the left, second on the right
    lcc_order u_cmp_order (
        .dtype(cmp_req.dtype),
        .x_val(cmp_req.first_operand),
        .y_val(cmp_req.second_operand),
        .less(cmp_less),
        .equal(cmp_equal),
        .nan(cmp_nan)
    );

    // Test value against each limit
    lcc_order u_lim_a_order (
        .dtype(range_req.dtype),
        .x_val(range_req.test_value),
        .y_val(range_req.range_limit_a),
        .less(a_less),
        .equal(a_equal),
        .nan()
    );

    lcc_order u_lim_b_order (
        .dtype(range_req.dtype),
        .x_val(range_req.test_value),
        .y_val(range_req.range_limit_b),
        .less(b_less),
        .equal(b_equal),
        .nan()
    );

    // ------------------------------------------------------------------
    // Relation select
    // ------------------------------------------------------------------
    logic rel_hit;
    logic cmp_flow_next;
    logic ok_flag_next;
    logic float_cmp;
    assign float_cmp = cmp_req.enable && (cmp_req.dtype == LCC_FLOAT_TYPE);
    always_comb
    begin
        unique case (cmp_req.op)
            LCC_EQUAL_OP: rel_hit = cmp_equal;
            LCC_NOT_EQUAL_OP: rel_hit = !cmp_equal && !cmp_nan;
            LCC_GREATER_OP: rel_hit = !cmp_less && !cmp_equal && !cmp_nan;
            LCC_GREATER_OR_EQUAL_OP: rel_hit = !cmp_less && !cmp_nan;
            LCC_LESS_OP: rel_hit = cmp_less;
            less_or_equal_op: rel_hit = cmp_less || cmp_equal;
            default: rel_hit = 1'b0; // Unused operator codes give no flow
        endcase
    end
    assign cmp_flow_next = cmp_req.enable && rel_hit;
    // Flag holds unless a float compare runs
    assign ok_flag_next = float_cmp ? !cmp_nan : float_compare_ok_flag;

    // ------------------------------------------------------------------
    // Range test, limits in either order, endpoints included
    // ------------------------------------------------------------------
    logic at_or_above_a;
    logic at_or_below_a;
    logic at_or_above_b;
    logic at_or_below_b;
    logic range_type_ok;
    logic range_flow_next;
    assign at_or_above_a = !a_less;
    assign at_or_below_a = a_less || a_equal;
    assign at_or_above_b = !b_less;
    assign at_or_below_b = b_less || b_equal;
    // Float is not a range type; such a request yields no flow
    assign range_type_ok = (range_req.dtype != LCC_FLOAT_TYPE);
    assign range_flow_next = range_req.enable && range_type_ok
                           && ((at_or_above_a && at_or_below_b) || (at_or_above_b && at_or_below_a));

    // ------------------------------------------------------------------
    // Contacts and continuation pair
    // ------------------------------------------------------------------
    logic cont_state_reg;
    logic cont_state_next;
    logic cont_valid_reg;
    logic cont_valid_next;
    logic ref_on;
    logic contact_flow_next;
    assign ref_on = (relay_req.ref_bit == 1'b1);
    // One flow out per element; open and closed contacts gate flow in, the continuation contact ignores it
    assign contact_flow_next = (relay_req.kind == LCC_OPEN_CONTACT) ? (relay_req.flow_in && ref_on)
                             : (relay_req.kind == LCC_CLOSED_CONTACT) ? (relay_req.flow_in && !ref_on)
                             : (relay_req.kind == LCC_CONT_CONTACT) ? (cont_valid_reg && cont_state_reg)
                             : 1'b0;
    // Coil stores its flow; a new sweep forgets earlier coils unless one runs now
    assign cont_state_next = relay_req.coil_exec ? relay_req.coil_flow
                           : (relay_req.sweep_start ? 1'b0 : cont_state_reg);
    assign cont_valid_next = relay_req.coil_exec || (cont_valid_reg && !relay_req.sweep_start);

    // ------------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cmp_flow <= LCC_FLOW_RST;
            range_flow <= LCC_FLOW_RST;
            float_compare_ok_flag <= LCC_FLAG_RST;
            contact_flow <= LCC_FLOW_RST;
        end
        else
        begin
            cmp_flow <= cmp_flow_next;
            range_flow <= range_flow_next;
            float_compare_ok_flag <= ok_flag_next;
            contact_flow <= contact_flow_next;
        end
    end

    // Continuation coil storage
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cont_state_reg <= LCC_FLOW_RST;
            cont_valid_reg <= 1'b0;
        end
        else
        begin
            cont_state_reg <= cont_state_next;
            cont_valid_reg <= cont_valid_next;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_coil_runs;
        relay_req.coil_exec && !relay_req.sweep_start;
    endsequence

    sequence s_cont_read;
        !relay_req.coil_exec && !relay_req.sweep_start && (relay_req.kind == LCC_CONT_CONTACT);
    endsequence

    sequence s_fresh_cont_read;
        relay_req.sweep_start && !relay_req.coil_exec ##1 s_cont_read;
    endsequence

    a_cmp_idle_dark: assert property (!cmp_req.enable ##1 $past(rst_n) |-> !cmp_flow)
        else $error("compare flow without enable");

    a_range_idle_dark: assert property (!range_req.enable ##1 $past(rst_n) |-> !range_flow)
        else $error("range flow without enable");

    a_signed_double_type_less_side: assert property (cmp_req.enable && (cmp_req.op == LCC_LESS_OP)
        && (cmp_req.dtype == signed_double_type) |=>
        cmp_flow == ($signed($past(cmp_req.first_operand)) < $signed($past(cmp_req.second_operand))))
        else $error("double less-than result wrong");

    a_word_ge_unsigned: assert property (cmp_req.enable && (cmp_req.op == LCC_GREATER_OR_EQUAL_OP)
        && (cmp_req.dtype == LCC_WORD_TYPE) |=>
        cmp_flow == ($past(cmp_req.first_operand[15:0]) >= $past(cmp_req.second_operand[15:0])))
        else $error("word compare not unsigned");

    a_int_range_window: assert property (range_req.enable && (range_req.dtype == LCC_SIGNED_INT_TYPE) |=>
        range_flow == (($signed($past(range_req.test_value[15:0])) >= $signed($past(range_req.range_limit_a[15:0]))
        && $signed($past(range_req.test_value[15:0])) <= $signed($past(range_req.range_limit_b[15:0])))
        || ($signed($past(range_req.test_value[15:0])) >= $signed($past(range_req.range_limit_b[15:0]))
        && $signed($past(range_req.test_value[15:0])) <= $signed($past(range_req.range_limit_a[15:0])))))
        else $error("signed range result wrong");

    a_word_range_edge: assert property (range_req.enable && (range_req.dtype == LCC_WORD_TYPE)
        && (range_req.test_value[15:0] == range_req.range_limit_b[15:0]) |=> range_flow)
        else $error("range endpoint excluded");

    a_open_contact_pass: assert property (relay_req.kind == LCC_OPEN_CONTACT |=>
        contact_flow == ($past(relay_req.flow_in) && $past(relay_req.ref_bit)))
        else $error("open contact flow wrong");

    a_closed_contact_pass: assert property (relay_req.kind == LCC_CLOSED_CONTACT |=>
        contact_flow == ($past(relay_req.flow_in) && !$past(relay_req.ref_bit)))
        else $error("closed contact flow wrong");

    a_cont_follows_coil: assert property (s_coil_runs ##1 s_cont_read |=> contact_flow == $past(relay_req.coil_flow, 2))
        else $error("continuation contact lost coil state");

    a_cont_none_dark: assert property (s_fresh_cont_read |=> !contact_flow)
        else $error("continuation contact flowed with no coil");

    a_float_nan_flag: assert property (float_cmp && cmp_nan |=> !float_compare_ok_flag && !cmp_flow)
        else $error("float flag not cleared on nan");

endmodule : lcc_unit

`default_nettype wire

// ---- lcc_unit_bench.sv ----
// Purpose: Self-checking bench for the ladder compare and contact unit
// Assumes: Inputs change at the falling edge; results are read one falling edge later
// Notes:   Expected values come from the relational, range and contact behaviour alone
`default_nettype none

module lcc_unit_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import lcc_pkg::*;

    // ------------------------------------------------------------------
    // Signals, clock and design instance
    // ------------------------------------------------------------------
    logic clock;
    logic rst_n;
    lcc_cmp_req_t cmp_req;
    lcc_range_req_t range_req;
    lcc_relay_req_t relay_req;
    logic cmp_flow;
    logic range_flow;
    logic float_compare_ok_flag;
    logic contact_flow;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;

    // Clock of 4 ns period
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    lcc_unit dut (
        .clock(clock),
        .rst_n(rst_n),
        .cmp_req(cmp_req),
        .range_req(range_req),
        .relay_req(relay_req),
        .cmp_flow(cmp_flow),
        .range_flow(range_flow),
        .float_compare_ok_flag(float_compare_ok_flag),
        .contact_flow(contact_flow)
    );

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic end_sim;
        begin
            $display("comparisons %0d mismatches %0d", checked, err_total);
            if (err_total == 0 && checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : end_sim

    task automatic chk(input string what, input logic seen, input logic want);
        begin
            checked++;
            if (seen !== want)
            begin
                err_total++;
                $display("BAD %s expected %b seen %b", what, want, seen);
            end
        end
    endtask : chk

    // Relation outcome from operand order: sgn -1 below, 0 equal, 1 above, 2 unordered
    function automatic logic rel_exp(input int op, input int sgn);
        begin
            rel_exp = 1'b0;
            if (sgn != 2)
            begin
                case (op)
                    0: rel_exp = (sgn == 0);
                    1: rel_exp = (sgn != 0);
                    2: rel_exp = (sgn > 0);
                    3: rel_exp = (sgn >= 0);
                    4: rel_exp = (sgn < 0);
                    5: rel_exp = (sgn <= 0);
                    default: rel_exp = 1'b0;
                endcase
            end
        end
    endfunction : rel_exp

    // Sweeps all eight operator codes over one operand pair
    task automatic run_cmp(input lcc_type_t dt, input logic [31:0] a, input logic [31:0] b,
                           input int sgn, input logic en);
        int op;
        begin
            for (op = 0; op < 8; op++)
            begin
                cmp_req = '{enable: en, op: lcc_op_t'(op[2:0]), dtype: dt, first_operand: a, second_operand: b};
                @(negedge clock);
                chk("cmp_flow", cmp_flow, en & rel_exp(op, sgn));
            end
            // Release and let an edge pass so the next call never drives in the same step
            cmp_req.enable = 1'b0;
            @(negedge clock);
            chk("cmp_idle", cmp_flow, 1'b0);
        end
    endtask : run_cmp

    task automatic rng(input lcc_type_t dt, input logic [31:0] t, input logic [31:0] a, input logic [31:0] b,
                       input logic en, input logic want);
        begin
            range_req = '{enable: en, dtype: dt, test_value: t, range_limit_a: a, range_limit_b: b};
            @(negedge clock);
            chk("range_flow", range_flow, want);
            range_req.enable = 1'b0;
            @(negedge clock);
            chk("range_idle", range_flow, 1'b0);
        end
    endtask : rng

    task automatic relay(input lcc_contact_t k, input logic fin, input logic rb, input logic cx,
                         input logic cf, input logic sw);
        begin
            relay_req = '{kind: k, flow_in: fin, ref_bit: rb, coil_exec: cx, coil_flow: cf, sweep_start: sw};
            @(negedge clock);
        end
    endtask : relay

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Continuation contact before and after a coil, across sweeps and resets
    task automatic test_continuation;
        begin
            relay(LCC_CONT_CONTACT, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
            chk("cont_fresh", contact_flow, 1'b0);
            relay(LCC_CONT_CONTACT, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
            chk("cont_same_cycle", contact_flow, 1'b0);
            relay(LCC_CONT_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("cont_on", contact_flow, 1'b1);
            relay(LCC_NO_CONTACT, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
            relay(LCC_CONT_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("cont_off", contact_flow, 1'b0);
            relay(LCC_NO_CONTACT, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
            relay(LCC_CONT_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("cont_coil_beats_sweep", contact_flow, 1'b1);
            relay(LCC_NO_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
            relay(LCC_CONT_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("cont_new_sweep", contact_flow, 1'b0);
            relay(LCC_NO_CONTACT, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
            rst_n = 1'b0;
            relay(LCC_CONT_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("flow_mid_reset", contact_flow, 1'b0);
            rst_n = 1'b1;
            relay(LCC_CONT_CONTACT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
            chk("cont_after_reset", contact_flow, 1'b0);
        end
    endtask : test_continuation

    // Open and closed contacts over every flow and reference combination
    task automatic test_contacts;
        int i;
        begin
            for (i = 0; i < 4; i++)
            begin
                relay(LCC_OPEN_CONTACT, i[1], i[0], 1'b0, 1'b0, 1'b0);
                chk("open_contact", contact_flow, i[1] & i[0]);
                relay(LCC_CLOSED_CONTACT, i[1], i[0], 1'b0, 1'b0, 1'b0);
                chk("closed_contact", contact_flow, i[1] & ~i[0]);
                relay(LCC_NO_CONTACT, i[1], i[0], 1'b0, 1'b0, 1'b0);
                chk("no_contact", contact_flow, 1'b0);
            end
        end
    endtask : test_contacts

    // Operand order and signedness per integer type, all operator codes including unused ones
    task automatic test_compare;
        begin
            run_cmp(LCC_SIGNED_INT_TYPE, 32'h0000_fffb, 32'h0000_0003, -1, 1'b1);
            run_cmp(LCC_SIGNED_INT_TYPE, 32'h1234_0003, 32'h0000_0003, 0, 1'b1);
            run_cmp(LCC_WORD_TYPE, 32'h0000_fffb, 32'h0000_0003, 1, 1'b1);
            run_cmp(signed_double_type, 32'hffff_fffb, 32'h0000_0003, -1, 1'b1);
            run_cmp(signed_double_type, 32'h0001_0000, 32'h0000_ffff, 1, 1'b1);
            run_cmp(signed_double_type, 32'h0000_0003, 32'hffff_fffb, 1, 1'b0);
        end
    endtask : test_compare

    // Float relations and the status flag that follows them
    task automatic test_float;
        begin
            run_cmp(LCC_FLOAT_TYPE, 32'hbf80_0000, 32'h3f80_0000, -1, 1'b1);
            chk("flag_ok", float_compare_ok_flag, 1'b1);
            run_cmp(LCC_FLOAT_TYPE, 32'h8000_0000, 32'h0000_0000, 0, 1'b1);
            run_cmp(LCC_FLOAT_TYPE, 32'h7fc0_0000, 32'h3f80_0000, 2, 1'b1);
            chk("flag_nan", float_compare_ok_flag, 1'b0);
            run_cmp(LCC_SIGNED_INT_TYPE, 32'h0000_0001, 32'h0000_0001, 0, 1'b1);
            chk("flag_hold_int", float_compare_ok_flag, 1'b0);
            run_cmp(LCC_FLOAT_TYPE, 32'h4000_0000, 32'h3f80_0000, 1, 1'b1);
            run_cmp(LCC_FLOAT_TYPE, 32'h7fc0_0000, 32'h3f80_0000, 2, 1'b0);
            chk("flag_hold_off", float_compare_ok_flag, 1'b1);
        end
    endtask : test_float

    // Range bounds in both orders, inclusive ends, per type
    task automatic test_range;
        begin
            rng(LCC_SIGNED_INT_TYPE, 32'h0000_0000, 32'h0000_0064, 32'h0000_0000, 1'b1, 1'b1);
            rng(LCC_SIGNED_INT_TYPE, 32'h0000_0064, 32'h0000_0000, 32'h0000_0064, 1'b1, 1'b1);
            rng(LCC_SIGNED_INT_TYPE, 32'h0000_0065, 32'h0000_0064, 32'h0000_0000, 1'b1, 1'b0);
            rng(LCC_SIGNED_INT_TYPE, 32'h0000_ffff, 32'h0000_0000, 32'h0000_0064, 1'b1, 1'b0);
            rng(LCC_SIGNED_INT_TYPE, 32'h0000_0100, 32'h0000_8000, 32'h0000_0010, 1'b1, 1'b0);
            rng(LCC_WORD_TYPE, 32'h0000_0100, 32'h0000_8000, 32'h0000_0010, 1'b1, 1'b1);
            rng(LCC_WORD_TYPE, 32'h0000_8001, 32'h0000_0010, 32'h0000_8000, 1'b1, 1'b0);
            rng(LCC_WORD_TYPE, 32'h0000_8000, 32'h0000_0010, 32'h0000_8000, 1'b1, 1'b1);
            rng(LCC_FLOAT_TYPE, 32'h3f80_0000, 32'h0000_0000, 32'h4000_0000, 1'b1, 1'b0);
            rng(signed_double_type, 32'hffff_ffff, 32'h0000_0010, 32'hffff_fff0, 1'b1, 1'b1);
            rng(signed_double_type, 32'h0000_0011, 32'hffff_fff0, 32'h0000_0010, 1'b1, 1'b0);
            rng(LCC_SIGNED_INT_TYPE, 32'h0000_0005, 32'h0000_0000, 32'h0000_0064, 1'b0, 1'b0);
        end
    endtask : test_range

    // ------------------------------------------------------------------
    // Main sequence and hang guard
    // ------------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        cmp_req = '0;
        range_req = '0;
        relay_req = '0;
        repeat (2) @(negedge clock);
        chk("flow_in_reset", cmp_flow | range_flow | contact_flow | float_compare_ok_flag, 1'b0);
        rst_n = 1'b1;
        test_continuation();
        test_contacts();
        test_compare();
        test_float();
        test_range();
        end_sim();
    end

    // Cuts a hang short well beyond the 158 cycles the scenarios need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            end_sim();
        end
    end

endmodule : lcc_unit_bench

`default_nettype wire
